// file: clksel_defines.vh
// Constants for the clock source select and oscillator fault block.
// Assumes a simple word-wide register port; offsets are word indices.
`ifndef CLKSEL_DEFINES_VH
`define CLKSEL_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_CLOCK_SELECT      4'h0
`define ADDR_OSC_FAULT         4'h1
`define ADDR_LOOP_CTRL         4'h2
`define ADDR_OSC_PRESENT       4'h3
`define ADDR_OSC_TRIM          4'h4

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SEL_AUX_LSB            0
`define SEL_SUB_LSB            4
`define SEL_MAIN_LSB           8
`define FAULT_LF_BIT           0
`define FAULT_HF_BIT           1
`define FAULT_DCO_BIT          2
`define FAULT_ANY_BIT          3
`define CTRL_LOOP_EN_BIT       0
`define CTRL_NMI_EN_BIT        1
`define PRESENT_LF_BIT         0
`define PRESENT_HF_BIT         1

// ----------------------------------------------------------------
// Reset values and source codes
// ----------------------------------------------------------------
`define SEL_RESET              12'h444
`define SRC_LF_CRYSTAL         3'h0
`define SRC_HF_CRYSTAL         3'h5
`define TRIM_RESET             13'h0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define LOCK_REF_PERIODS       32'h00000400

`endif

// file: freq_tracker.v
// Frequency tracking loop: steps the oscillator tap and modulation
// fields toward a target ratio of oscillator to reference edges.
// Assumes reference and oscillator ticks are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none
module freq_tracker #(
    parameter TAP_W = 5,
    parameter MOD_W = 5,
    parameter CNT_W = 16
) (
    input wire i_clk,                  // System clock
    input wire i_reset,                // Synchronous reset
    input wire i_enable,               // Loop enabled
    input wire i_ref_tick,             // Reference clock period tick
    input wire i_osc_tick,             // Oscillator edge tick
    input wire [CNT_W-1:0] i_target,   // Oscillator edges per ref period
    output reg [TAP_W-1:0] o_tap,      // Oscillator tap field
    output reg [MOD_W-1:0] o_mod       // Modulation field
);
    reg [CNT_W-1:0] edge_cnt_ff;
    reg [TAP_W+MOD_W-1:0] trim_ff;
    reg [TAP_W+MOD_W-1:0] nxt_trim;
    localparam [TAP_W+MOD_W-1:0] TRIM_MAX = {(TAP_W+MOD_W){1'b1}};
    localparam [TAP_W+MOD_W-1:0] TRIM_ONE = 1;

    // ----------------------------------------------------------------
    // Tap and modulation act as one combined counter, so a modulation
    // wrap carries into the tap cleanly
    // ----------------------------------------------------------------
    always @*
    begin
        nxt_trim = trim_ff;
        if (i_enable && i_ref_tick)
        begin
            if (edge_cnt_ff < i_target && trim_ff != TRIM_MAX)
                nxt_trim = trim_ff + TRIM_ONE;
            else if (edge_cnt_ff > i_target && trim_ff != 0)
                nxt_trim = trim_ff - TRIM_ONE;
        end
    end

    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            edge_cnt_ff <= {CNT_W{1'b0}};
            trim_ff <= {(TAP_W+MOD_W){1'b0}};
            o_tap <= {TAP_W{1'b0}};
            o_mod <= {MOD_W{1'b0}};
        end
        else
        begin
            if (i_ref_tick)
                edge_cnt_ff <= {CNT_W{1'b0}};
            else if (i_osc_tick && edge_cnt_ff != {CNT_W{1'b1}})
                edge_cnt_ff <= edge_cnt_ff + 1'b1;
            trim_ff <= nxt_trim;
            o_tap <= nxt_trim[TAP_W+MOD_W-1:MOD_W];
            o_mod <= nxt_trim[MOD_W-1:0];
        end
    end
endmodule
`default_nettype wire

// file: clock_source_select.v
// Clock source selection with crystal fault flags and fault interrupt.
// Assumes a word-wide register port with read data one cycle later,
// and oscillator status/tick inputs synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
`include "clksel_defines.vh"

module clock_source_select #(
    parameter SEL_W = 3,
    parameter TAP_W = 5,
    parameter MOD_W = 5,
    parameter CNT_W = 16
) (
    input wire i_clk,                  // System clock, 200 MHz
    input wire i_reset,                // Synchronous reset, active high
    input wire [3:0] i_addr,           // Register word index
    input wire [31:0] i_wdata,         // Write data
    input wire i_wr,                   // Write strobe
    input wire i_rd,                   // Read strobe
    output reg [31:0] o_rdata,         // Read data, cycle after strobe
    input wire i_lf_osc_fail,          // Low-freq crystal not oscillating
    input wire i_hf_osc_fail,          // High-freq crystal not oscillating
    input wire i_dco_fail,             // Oscillator tap at a limit
    input wire i_ref_tick,             // Loop reference clock tick
    input wire i_osc_tick,             // Oscillator edge tick
    output reg [SEL_W-1:0] o_main_clock_source_sel,      // Main clock mux
    output reg [SEL_W-1:0] o_subsystem_clock_source_sel, // Sub clock mux
    output reg [SEL_W-1:0] o_aux_clock_source_sel,       // Aux clock mux
    output reg o_frequency_locked_loop_en,               // Loop enable
    output wire [TAP_W-1:0] o_dco_tap,                   // Oscillator tap
    output wire [MOD_W-1:0] o_dco_mod,                   // Modulation
    output wire o_oscillator_fault_interrupt_flag,       // Summary fault
    output wire o_osc_fault_nmi                          // Fault interrupt
);
    reg [11:0] sel_ff;
    reg [2:0] fault_ff;
    reg [2:0] nxt_fault;
    reg nmi_en_ff;
    reg loop_en_ff;
    reg [1:0] present_ff;
    reg [CNT_W-1:0] target_ff;
    reg sel_change_ff;
    wire wr_sel;
    wire wr_fault;
    wire [11:0] new_sel;
    wire any_change;
    wire lf_used;
    wire hf_used;
    wire any_fault;
    wire [TAP_W-1:0] tap;
    wire [MOD_W-1:0] modv;

    // ----------------------------------------------------------------
    // Register decode
    // ----------------------------------------------------------------
    assign wr_sel = i_wr && (i_addr == `ADDR_CLOCK_SELECT);
    assign wr_fault = i_wr && (i_addr == `ADDR_OSC_FAULT);
    assign new_sel = i_wdata[11:0];
    assign any_change = wr_sel && (new_sel != sel_ff);

    // Crystal in use by any of the three selectors
    assign lf_used =
        (sel_ff[`SEL_AUX_LSB +: 3] == `SRC_LF_CRYSTAL) ||
        (sel_ff[`SEL_SUB_LSB +: 3] == `SRC_LF_CRYSTAL) ||
        (sel_ff[`SEL_MAIN_LSB +: 3] == `SRC_LF_CRYSTAL);
    assign hf_used =
        (sel_ff[`SEL_AUX_LSB +: 3] == `SRC_HF_CRYSTAL) ||
        (sel_ff[`SEL_SUB_LSB +: 3] == `SRC_HF_CRYSTAL) ||
        (sel_ff[`SEL_MAIN_LSB +: 3] == `SRC_HF_CRYSTAL);

    // ----------------------------------------------------------------
    // Fault flags
    // ----------------------------------------------------------------
    // The switch briefly requests every source, so the change pulse
    // probes both crystals whichever field moved. This reproduces the
    // known spurious flag rather than hiding it from software.
    always @*
    begin
        nxt_fault = fault_ff;
        if (wr_fault)
            nxt_fault = fault_ff & i_wdata[2:0];
        if (sel_change_ff && !present_ff[`PRESENT_LF_BIT])
            nxt_fault[`FAULT_LF_BIT] = 1'b1;
        if (sel_change_ff && !present_ff[`PRESENT_HF_BIT])
            nxt_fault[`FAULT_HF_BIT] = 1'b1;
        if (lf_used && i_lf_osc_fail)
            nxt_fault[`FAULT_LF_BIT] = 1'b1;
        if (hf_used && i_hf_osc_fail)
            nxt_fault[`FAULT_HF_BIT] = 1'b1;
        if (loop_en_ff && i_dco_fail)
            nxt_fault[`FAULT_DCO_BIT] = 1'b1;
    end

    assign any_fault = |fault_ff;
    assign o_oscillator_fault_interrupt_flag = any_fault;
    assign o_osc_fault_nmi = any_fault && nmi_en_ff;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            sel_ff <= `SEL_RESET;
            fault_ff <= 3'h0;
            nmi_en_ff <= 1'b0;
            loop_en_ff <= 1'b0;
            present_ff <= 2'h0;
            target_ff <= {CNT_W{1'b0}};
            sel_change_ff <= 1'b0;
        end
        else
        begin
            if (wr_sel)
                sel_ff <= new_sel;
            sel_change_ff <= any_change;
            fault_ff <= nxt_fault;
            if (i_wr && i_addr == `ADDR_LOOP_CTRL)
            begin
                loop_en_ff <= i_wdata[`CTRL_LOOP_EN_BIT];
                nmi_en_ff <= i_wdata[`CTRL_NMI_EN_BIT];
            end
            if (i_wr && i_addr == `ADDR_OSC_PRESENT)
                present_ff <= i_wdata[1:0];
            if (i_wr && i_addr == `ADDR_OSC_TRIM)
                target_ff <= i_wdata[CNT_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Clock mux outputs, registered so each mux sees one clean change
    // ----------------------------------------------------------------
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_main_clock_source_sel <= 3'h4;
            o_subsystem_clock_source_sel <= 3'h4;
            o_aux_clock_source_sel <= 3'h4;
            o_frequency_locked_loop_en <= 1'b0;
        end
        else
        begin
            o_main_clock_source_sel <= sel_ff[`SEL_MAIN_LSB +: 3];
            o_subsystem_clock_source_sel <= sel_ff[`SEL_SUB_LSB +: 3];
            o_aux_clock_source_sel <= sel_ff[`SEL_AUX_LSB +: 3];
            o_frequency_locked_loop_en <= loop_en_ff;
        end
    end

    // ----------------------------------------------------------------
    // Frequency tracking
    // ----------------------------------------------------------------
    freq_tracker #(
        .TAP_W(TAP_W),
        .MOD_W(MOD_W),
        .CNT_W(CNT_W)
    ) u_tracker (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_enable(loop_en_ff),
        .i_ref_tick(i_ref_tick),
        .i_osc_tick(i_osc_tick),
        .i_target(target_ff),
        .o_tap(tap),
        .o_mod(modv)
    );
    assign o_dco_tap = tap;
    assign o_dco_mod = modv;

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    always @(posedge i_clk)
    begin
        if (i_reset)
            o_rdata <= 32'h00000000;
        else if (i_rd)
        begin
            case (i_addr)
                `ADDR_CLOCK_SELECT: o_rdata <= {20'h00000, sel_ff};
                `ADDR_OSC_FAULT: o_rdata <= {28'h0000000, any_fault, fault_ff};
                `ADDR_LOOP_CTRL: o_rdata <= {30'h00000000, nmi_en_ff,
                    loop_en_ff};
                `ADDR_OSC_PRESENT: o_rdata <= {30'h00000000, present_ff};
                `ADDR_OSC_TRIM: o_rdata <= {{(32-CNT_W){1'b0}}, target_ff};
                4'h5: o_rdata <= {{(32-TAP_W-MOD_W){1'b0}}, tap, modv};
                default: o_rdata <= 32'h00000000;
            endcase
        end
        else
            o_rdata <= 32'h00000000;
    end
endmodule
`default_nettype wire

// file: clksel_props.sv
// Concurrent checks for the clock source select block.
// Bound onto clock_source_select; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module clksel_props #(
    parameter SEL_W = 3,
    parameter TAP_W = 5,
    parameter MOD_W = 5
) (
    input wire logic i_clk, // System clock
    input wire logic i_reset, // Sync reset
    input wire logic [3:0] i_addr, // Word index
    input wire logic [31:0] i_wdata, // Write data
    input wire logic i_wr, // Write strobe
    input wire logic i_ref_tick, // Reference tick
    input wire logic [SEL_W-1:0] o_main_clock_source_sel, // Main mux
    input wire logic [SEL_W-1:0] o_subsystem_clock_source_sel, // Sub mux
    input wire logic [SEL_W-1:0] o_aux_clock_source_sel, // Aux mux
    input wire logic o_frequency_locked_loop_en, // Loop enable
    input wire logic [TAP_W-1:0] o_dco_tap, // Tap field
    input wire logic [MOD_W-1:0] o_dco_mod, // Modulation field
    input wire logic o_oscillator_fault_interrupt_flag, // Summary
    input wire logic o_osc_fault_nmi // Fault interrupt
);
    logic nmi_en_ff;
    logic loop_en_ff;
    logic [1:0] present_ff;
    logic [11:0] sel_ff;
    wire sel_wr = i_wr && i_addr == 4'h0;

    // ----------------------------------------------------------------
    // Shadows of the registers that decide flags and interrupt
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            nmi_en_ff <= 1'b0;
            loop_en_ff <= 1'b0;
            present_ff <= 2'b00;
            sel_ff <= 12'h444;
        end
        else if (i_wr)
        begin
            if (i_addr == 4'h2)
                nmi_en_ff <= i_wdata[1];
            if (i_addr == 4'h2)
                loop_en_ff <= i_wdata[0];
            if (i_addr == 4'h3)
                present_ff <= i_wdata[1:0];
            if (i_addr == 4'h0)
                sel_ff <= i_wdata[11:0] & 12'h777;
        end
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    a_sel_follows: assert property (
        sel_wr ##1 !sel_wr |=> {o_main_clock_source_sel,
        o_subsystem_clock_source_sel, o_aux_clock_source_sel} ==
        {$past(i_wdata[10:8], 2), $past(i_wdata[6:4], 2),
        $past(i_wdata[2:0], 2)})
        else $error("clock select outputs do not follow write");
    a_spurious_flag: assert property (
        sel_wr && (i_wdata[11:0] & 12'h777) != sel_ff
        && present_ff != 2'b11 |-> ##2 o_oscillator_fault_interrupt_flag)
        else $error("select change left absent crystal flag clear");
    a_flag_sticky: assert property (
        o_oscillator_fault_interrupt_flag && !(i_wr && i_addr == 4'h1)
        |=> o_oscillator_fault_interrupt_flag)
        else $error("fault flag dropped without a clear");
    a_nmi_gate: assert property (
        o_osc_fault_nmi == (o_oscillator_fault_interrupt_flag && nmi_en_ff))
        else $error("fault interrupt does not match flag and enable");
    a_trim_hold: assert property (
        !(i_ref_tick && loop_en_ff)
        |=> $stable({o_dco_tap, o_dco_mod}))
        else $error("trim moved without an enabled reference tick");
    a_trim_step: assert property (
        i_ref_tick && loop_en_ff |=>
        (({o_dco_tap, o_dco_mod} - $past({o_dco_tap, o_dco_mod}))
        inside {10'h000, 10'h001, 10'h3FF}))
        else $error("trim stepped by more than one");
endmodule
`default_nettype wire

// file: test_clock_source_select.sv
// Self-checking bench for the clock source select block.
// Drives the register port and oscillator inputs; no partner model.
`timescale 1ns/1ps
`default_nettype none
`include "clksel_defines.vh"
module test_clock_source_select;
    logic i_clk = 1'b0;
    logic i_reset = 1'b1;
    logic [3:0] i_addr = 4'h0;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_lf_osc_fail = 1'b0;
    logic i_hf_osc_fail = 1'b0;
    logic i_dco_fail = 1'b0;
    logic i_ref_tick = 1'b0;
    logic i_osc_tick = 1'b0;
    logic [31:0] o_rdata;
    logic [2:0] o_main_clock_source_sel;
    logic [2:0] o_subsystem_clock_source_sel;
    logic [2:0] o_aux_clock_source_sel;
    logic o_frequency_locked_loop_en;
    logic [4:0] o_dco_tap;
    logic [4:0] o_dco_mod;
    logic o_oscillator_fault_interrupt_flag;
    logic o_osc_fault_nmi;
    int error_cnt = 0;
    int cmp_count = 0;

    clock_source_select DUT (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr,
        .i_rd, .o_rdata, .i_lf_osc_fail, .i_hf_osc_fail, .i_dco_fail,
        .i_ref_tick, .i_osc_tick, .o_main_clock_source_sel,
        .o_subsystem_clock_source_sel, .o_aux_clock_source_sel,
        .o_frequency_locked_loop_en, .o_dco_tap, .o_dco_mod,
        .o_oscillator_fault_interrupt_flag, .o_osc_fault_nmi);

    initial forever #2.5 i_clk = ~i_clk;

    // ----------------------------------------------------------------
    // Access and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, exp);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // Osc edges, then one reference tick closing the period
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge i_clk);
            i_osc_tick <= 1'b1;
            @(posedge i_clk);
            i_osc_tick <= 1'b0;
        end
        @(posedge i_clk);
        i_ref_tick <= 1'b1;
        @(posedge i_clk);
        i_ref_tick <= 1'b0;
        #1;
    endtask
    task automatic sel(input logic [8:0] exp);
        chk({23'h0, o_main_clock_source_sel, o_subsystem_clock_source_sel,
            o_aux_clock_source_sel}, {23'h0, exp});
    endtask
    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge i_clk);
        i_reset <= 1'b0;
        rd(4'h0, {20'h0, `SEL_RESET});
        rd(4'h1, 32'h0);
        wr(4'h2, 32'h2);
        wr(4'h0, 32'h412);
        cyc(2);
        sel(9'h10A);
        chk({31'h0, o_osc_fault_nmi}, 32'h1);
        rd(4'h1, 32'hB);
        cyc(5);
        chk({31'h0, o_oscillator_fault_interrupt_flag}, 32'h1);
        wr(4'h1, 32'h0);
        rd(4'h1, 32'h0);
        wr(4'h0, 32'h412);
        cyc(2);
        rd(4'h1, 32'h0);
        wr(4'h2, 32'h0);
        wr(4'h3, 32'h1);
        wr(4'h0, 32'h123);
        cyc(2);
        sel(9'h053);
        chk({31'h0, o_osc_fault_nmi}, 32'h0);
        rd(4'h1, 32'hA);
        wr(4'h1, 32'h0);
        wr(4'h3, 32'h3);
        wr(4'h0, 32'h500);
        cyc(2);
        rd(4'h1, 32'h0);
        // A crystal in use that really fails must still flag
        @(posedge i_clk) i_hf_osc_fail <= 1'b1;
        cyc(3);
        rd(4'h1, 32'hA);
        @(posedge i_clk) i_hf_osc_fail <= 1'b0;
        wr(4'h1, 32'h0);
        rd(4'hF, 32'h0);
        wr(4'hF, 32'hFFF);
        rd(4'h0, 32'h500);
        wr(4'h4, 32'h3);
        wr(4'h2, 32'h1);
        cyc(1);
        chk({31'h0, o_frequency_locked_loop_en}, 32'h1);
        tick(0);
        chk({22'h0, o_dco_tap, o_dco_mod}, 32'h1);
        tick(5);
        chk({22'h0, o_dco_tap, o_dco_mod}, 32'h0);
        tick(5);
        chk({22'h0, o_dco_tap, o_dco_mod}, 32'h0);
        tick(1);
        // Settling wait: edges match target, so trim must hold
        repeat (1024) tick(3);
        rd(4'h5, 32'h1);
        @(posedge i_clk) i_dco_fail <= 1'b1;
        cyc(2);
        rd(4'h1, 32'hC);
        @(posedge i_clk) i_dco_fail <= 1'b0;
        wr(4'h1, 32'h0);
        wr(4'h2, 32'h0);
        tick(0);
        chk({22'h0, o_dco_tap, o_dco_mod}, 32'h1);
        print_verdict;
    end

    initial
    begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        $display("ERROR %0t: run did not finish", $time);
        print_verdict;
    end
endmodule

bind clock_source_select clksel_props #(.SEL_W(SEL_W), .TAP_W(TAP_W),
    .MOD_W(MOD_W)) u_props (.i_clk, .i_reset, .i_addr, .i_wdata, .i_wr,
    .i_ref_tick, .o_main_clock_source_sel, .o_subsystem_clock_source_sel,
    .o_aux_clock_source_sel, .o_frequency_locked_loop_en, .o_dco_tap,
    .o_dco_mod, .o_oscillator_fault_interrupt_flag, .o_osc_fault_nmi);
`default_nettype wire
